// *** logic/rtcc_pkg.sv ***
// shared constants, register map and types of the calendar clock block
package rtcc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_SECONDS = 8'h00;
  localparam logic [7:0] OFF_MINUTES = 8'h04;
  localparam logic [7:0] OFF_HOURS = 8'h08;
  localparam logic [7:0] OFF_WEEKDAY = 8'h0C;
  localparam logic [7:0] OFF_DAY = 8'h10;
  localparam logic [7:0] OFF_MONTH = 8'h14;
  localparam logic [7:0] OFF_YEAR = 8'h18;
  localparam logic [7:0] OFF_CLOCK_CONTROL = 8'h1C;
  localparam logic [7:0] OFF_CLOCK_SOURCE = 8'h20;
  localparam logic [7:0] OFF_PERIODIC_SELECT = 8'h24;
  localparam logic [7:0] OFF_ALARM_MINUTE = 8'h28;
  localparam logic [7:0] OFF_ALARM_HOUR = 8'h2C;
  localparam logic [7:0] OFF_ALARM_WEEKDAY = 8'h30;
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h34;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h38;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h3C;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SEC_BUSY_BIT = 7;
  localparam int CTL_START_BIT = 0;
  localparam int CTL_RUN_BIT = 1;
  localparam int CTL_H24_BIT = 2;
  localparam int CTL_PM_BIT = 3;
  localparam int CTL_COE_BIT = 4;
  localparam int IF_PER_BIT = 0;
  localparam int IF_ALM_BIT = 1;
  localparam int IF_AIE_BIT = 2;
  localparam int IRQ_PER_BIT = 0;
  localparam int IRQ_ALM_BIT = 1;
  localparam int ALM_EN_BIT = 7;
  localparam int DIV_1HZ_BIT = 14;
  localparam int DIV_64HZ_BIT = 8;

  // ----------------------------------------------------------------
  // timing and limits
  // ----------------------------------------------------------------
  localparam int COUNT_SRC_HZ = 32768;
  localparam logic [1:0] START_TICKS = 2'h2;
  localparam logic [1:0] STOP_TICKS = 2'h3;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] HOUR24_MAX = 8'h23;
  localparam logic [7:0] HOUR12_TOP = 8'h12;
  localparam logic [7:0] HOUR12_PM_EDGE = 8'h11;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  localparam logic [7:0] BCD_ONE = 8'h01;
  localparam logic [2:0] WDAY_MAX = 3'h6;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RUN_STOPPED = 2'b00,
    RUN_STARTING = 2'b01,
    RUN_RUNNING = 2'b10,
    RUN_STOPPING = 2'b11
  } rtcc_run_e;

  typedef enum logic [2:0] {
    PER_NONE = 3'b000,
    PER_SEC = 3'b001,
    PER_MIN = 3'b010,
    PER_HOUR = 3'b011,
    PER_DAY = 3'b100,
    PER_MON = 3'b101,
    PER_YEAR = 3'b110
  } rtcc_per_e;

  localparam logic [1:0] COSEL_1HZ = 2'b01;
  localparam logic [1:0] COSEL_64HZ = 2'b10;

  // tens and units digits of every time field except weekday and the pm flag
  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic [2:0] wday;
    logic [5:0] day;
    logic [4:0] mon;
    logic [7:0] year;
    logic pm;
  } rtcc_time_s;

  // one-cycle pulses, one for each field that stepped, weekday sharing the day pulse
  typedef struct packed {
    logic sec;
    logic min;
    logic hour;
    logic day;
    logic mon;
    logic year;
  } rtcc_carry_s;

endpackage

// *** logic/rtcc_time.sv ***
// time-of-day and calendar counter chain with update-busy indication
`timescale 1ns/1ps
module rtcc_time
  import rtcc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // control
  input wire logic sec_pulse_i,
  input wire logic fmt24_i,
  input wire logic load_i,
  input wire rtcc_time_s load_val_i,
  // state
  output rtcc_time_s time_o,
  output rtcc_carry_s carry_o,
  output logic busy_o
);

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02) begin
      month_days = leap ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      month_days = 8'h30;
    end else begin
      month_days = 8'h31;
    end
  endfunction

  logic upd_pend;
  rtcc_time_s next_time;
  rtcc_carry_s next_carry;

  // ----------------------------------------------------------------
  // carry chain, evaluated once per second
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] s;
    logic [7:0] mi;
    logic [7:0] h;
    logic [7:0] d;
    logic [7:0] mo;
    logic [7:0] s_inc;
    logic [7:0] mi_inc;
    logic [7:0] h_inc;
    logic [7:0] d_inc;
    logic [7:0] mo_inc;
    logic [7:0] d_last;
    s = {1'b0, time_o.sec};
    mi = {1'b0, time_o.min};
    h = {2'b0, time_o.hour};
    d = {2'b0, time_o.day};
    mo = {3'b0, time_o.mon};
    s_inc = bcd_inc(s);
    mi_inc = bcd_inc(mi);
    h_inc = bcd_inc(h);
    d_inc = bcd_inc(d);
    mo_inc = bcd_inc(mo);
    d_last = month_days(mo, time_o.year);
    next_time = time_o;
    next_carry = '0;
    next_carry.sec = 1'b1;
    // [R11] bcd digit counting
    next_time.sec = (s == SEC_MAX) ? 7'h0 : s_inc[6:0];
    next_carry.min = (s == SEC_MAX);
    if (next_carry.min) begin
      next_time.min = (mi == SEC_MAX) ? 7'h0 : mi_inc[6:0];
      next_carry.hour = (mi == SEC_MAX);
    end
    if (next_carry.hour) begin
      if (fmt24_i) begin
        next_time.hour = (h == HOUR24_MAX) ? 6'h0 : h_inc[5:0];
        next_carry.day = (h == HOUR24_MAX);
      end else begin
        next_time.hour = (h == HOUR12_TOP) ? BCD_ONE[5:0] : h_inc[5:0];
        next_time.pm = (h == HOUR12_PM_EDGE) ? ~time_o.pm : time_o.pm;
        next_carry.day = (h == HOUR12_PM_EDGE) && time_o.pm;
      end
    end
    if (next_carry.day) begin
      next_time.wday = (time_o.wday == WDAY_MAX) ? 3'h0 : time_o.wday + 3'h1;
      next_time.day = (d == d_last) ? BCD_ONE[5:0] : d_inc[5:0];
      next_carry.mon = (d == d_last);
    end
    if (next_carry.mon) begin
      next_time.mon = (mo == MON_MAX) ? BCD_ONE[4:0] : mo_inc[4:0];
      next_carry.year = (mo == MON_MAX);
    end
    if (next_carry.year) begin
      next_time.year = (time_o.year == YEAR_MAX) ? 8'h0 : bcd_inc(time_o.year);
    end
  end

  // ----------------------------------------------------------------
  // update sequence: busy rises a cycle before fields move, falls after
  // ----------------------------------------------------------------
  // [R15] busy spans the update
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      upd_pend <= 1'b0;
      busy_o <= 1'b0;
    end else if (sec_pulse_i) begin
      upd_pend <= 1'b1;
      busy_o <= 1'b1;
    end else begin
      upd_pend <= 1'b0;
      busy_o <= upd_pend;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      time_o <= '{sec: 7'h0, min: 7'h0, hour: 6'h0, wday: 3'h0, day: 6'h01,
                  mon: 5'h01, year: 8'h0, pm: 1'b0};
      carry_o <= '0;
    end else if (load_i) begin
      time_o <= load_val_i;
      carry_o <= '0;
    end else if (upd_pend) begin
      time_o <= next_time;
      carry_o <= next_carry;
    end else begin
      carry_o <= '0;
    end
  end

endmodule

// *** logic/rtcc_top.sv ***
// calendar clock core: run control, time registers, alarm, irq, axi4-lite slave
//
// Behaviour
// [R1] start request raises running flag within two ticks
// [R2] software waits for running flag after start
// [R3] stop request drops running flag within three ticks
// [R4] software waits for running flag clear
// [R5] time and format settings written only while stopped (format writes are also taken while starting)
// [R6] periodic select programmed last before start
// [R7] alarm writes only while busy flag clear (the core takes alarm writes whatever the busy flag shows)
// [R8] busy flag shown in seconds register
// [R9] guard multi-register reads against updates
// [R10] periodic request flag set for polling
// [R11] time held as tens and units digits
// [R12] read time registers back to back
// [R13] alarm match sets flag and request
// [R14] periodic flag rise sets periodic request
// [R15] busy covers whole carry chain update
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module rtcc_top
  import rtcc_pkg::*;
#(
  parameter int SUBCLK_PER_SEC = COUNT_SRC_HZ
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // count source, one-cycle pulse per sub-clock period
  input wire logic count_src_tick_i,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // outputs
  output logic irq_o,
  output logic clock_out_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rtcc_run_e run_state;
  logic [1:0] tick_cnt;
  logic count_start_request;
  logic count_running_flag;
  logic hour_format_select;
  logic clock_out_enable;
  logic [1:0] clock_out_select;
  rtcc_per_e periodic_irq_select_reg;
  logic [7:0] alarm_minute_reg;
  logic [7:0] alarm_hour_reg;
  logic [7:0] alarm_weekday_reg;
  logic periodic_flag;
  logic alarm_flag;
  logic alarm_irq_enable;
  logic [1:0] periodic_irq_control_reg;
  logic [1:0] irq_mask;
  logic [14:0] presc;
  logic src_div;
  logic sec_pulse;
  logic per_flag_d;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;
  logic time_load;
  rtcc_time_s load_val;
  rtcc_time_s cur_time;
  rtcc_carry_s carry;
  logic update_busy_flag;
  logic per_evt;
  logic alarm_match;
  logic wr_low;

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_low = wr_fire && w_strb[0];

  // ----------------------------------------------------------------
  // time counter
  // ----------------------------------------------------------------
  rtcc_time u_time (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .sec_pulse_i(sec_pulse),
    .fmt24_i(hour_format_select),
    .load_i(time_load),
    .load_val_i(load_val),
    .time_o(cur_time),
    .carry_o(carry),
    .busy_o(update_busy_flag)
  );

  // time writes are dropped while counting so a write can never race the carry chain
  always_comb begin
    load_val = cur_time;
    time_load = 1'b0;
    if (wr_low && !count_running_flag && run_state == RUN_STOPPED) begin
      // [R5] stopped-only time writes
      time_load = 1'b1;
      case (aw_addr)
        OFF_SECONDS: load_val.sec = w_data[6:0];
        OFF_MINUTES: load_val.min = w_data[6:0];
        OFF_HOURS: load_val.hour = w_data[5:0];
        OFF_WEEKDAY: load_val.wday = w_data[2:0];
        OFF_DAY: load_val.day = w_data[5:0];
        OFF_MONTH: load_val.mon = w_data[4:0];
        OFF_YEAR: load_val.year = w_data[7:0];
        OFF_CLOCK_CONTROL: load_val.pm = w_data[CTL_PM_BIT];
        default: time_load = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      run_state <= RUN_STOPPED;
      tick_cnt <= 2'h0;
      count_running_flag <= 1'b0;
    end else begin
      case (run_state)
        RUN_STOPPED: begin
          tick_cnt <= 2'h0;
          if (count_start_request) begin
            run_state <= RUN_STARTING;
          end
        end
        RUN_STARTING: begin
          // [R1] running within two ticks
          if (!count_start_request) begin
            run_state <= RUN_STOPPED;
          end else if (count_src_tick_i) begin
            tick_cnt <= tick_cnt + 2'h1;
            if (tick_cnt == START_TICKS - 2'h1) begin
              run_state <= RUN_RUNNING;
              count_running_flag <= 1'b1;
              tick_cnt <= 2'h0;
            end
          end
        end
        RUN_RUNNING: begin
          if (!count_start_request) begin
            run_state <= RUN_STOPPING;
          end
        end
        RUN_STOPPING: begin
          // [R3] stopped within three ticks
          if (count_src_tick_i) begin
            tick_cnt <= tick_cnt + 2'h1;
            if (tick_cnt == STOP_TICKS - 2'h1) begin
              run_state <= RUN_STOPPED;
              count_running_flag <= 1'b0;
              tick_cnt <= 2'h0;
            end
          end
        end
        default: run_state <= RUN_STOPPED;
      endcase
    end
  end

  // one-second prescaler, counting only while running
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      presc <= 15'h0;
      sec_pulse <= 1'b0;
      src_div <= 1'b0;
    end else begin
      sec_pulse <= 1'b0;
      if (count_src_tick_i) begin
        src_div <= ~src_div;
      end
      if (count_src_tick_i && count_running_flag) begin
        if (presc == 15'(SUBCLK_PER_SEC - 1)) begin
          presc <= 15'h0;
          sec_pulse <= 1'b1;
        end else begin
          presc <= presc + 15'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      clock_out_o <= 1'b0;
    end else if (!clock_out_enable) begin
      clock_out_o <= 1'b0;
    end else if (clock_out_select == COSEL_1HZ) begin
      clock_out_o <= presc[DIV_1HZ_BIT];
    end else if (clock_out_select == COSEL_64HZ) begin
      clock_out_o <= presc[DIV_64HZ_BIT];
    end else begin
      clock_out_o <= src_div;
    end
  end

  // ----------------------------------------------------------------
  // periodic and alarm events
  // ----------------------------------------------------------------
  always_comb begin
    case (periodic_irq_select_reg)
      PER_SEC: per_evt = carry.sec;
      PER_MIN: per_evt = carry.min;
      PER_HOUR: per_evt = carry.hour;
      PER_DAY: per_evt = carry.day;
      PER_MON: per_evt = carry.mon;
      PER_YEAR: per_evt = carry.year;
      default: per_evt = 1'b0;
    endcase
  end

  // only enabled alarm fields take part in the compare
  assign alarm_match = carry.min
    && (!alarm_minute_reg[ALM_EN_BIT] || alarm_minute_reg[6:0] == cur_time.min)
    && (!alarm_hour_reg[ALM_EN_BIT] || alarm_hour_reg[5:0] == cur_time.hour)
    && (!alarm_weekday_reg[ALM_EN_BIT] || alarm_weekday_reg[2:0] == cur_time.wday)
    && (alarm_minute_reg[ALM_EN_BIT] || alarm_hour_reg[ALM_EN_BIT]
        || alarm_weekday_reg[ALM_EN_BIT]);

  // hardware set beats a software clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      periodic_flag <= 1'b0;
      alarm_flag <= 1'b0;
      per_flag_d <= 1'b0;
      periodic_irq_control_reg <= 2'h0;
    end else begin
      per_flag_d <= periodic_flag;
      // [R10] periodic flag set
      if (per_evt) begin
        periodic_flag <= 1'b1;
      end else if (wr_low && aw_addr == OFF_IRQ_FLAG && w_data[IF_PER_BIT]) begin
        periodic_flag <= 1'b0;
      end
      // [R13] alarm flag on match
      if (alarm_match) begin
        alarm_flag <= 1'b1;
      end else if (wr_low && aw_addr == OFF_IRQ_FLAG && w_data[IF_ALM_BIT]) begin
        alarm_flag <= 1'b0;
      end
      // [R14] request on flag rise
      if (periodic_flag && !per_flag_d) begin
        periodic_irq_control_reg[IRQ_PER_BIT] <= 1'b1;
      end else if (wr_low && aw_addr == OFF_IRQ_STATUS && w_data[IRQ_PER_BIT]) begin
        periodic_irq_control_reg[IRQ_PER_BIT] <= 1'b0;
      end
      // [R13] request when enabled
      if (alarm_match && alarm_irq_enable) begin
        periodic_irq_control_reg[IRQ_ALM_BIT] <= 1'b1;
      end else if (wr_low && aw_addr == OFF_IRQ_STATUS && w_data[IRQ_ALM_BIT]) begin
        periodic_irq_control_reg[IRQ_ALM_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(periodic_irq_control_reg & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // software-written settings
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count_start_request <= 1'b0;
      hour_format_select <= 1'b1;
      clock_out_enable <= 1'b0;
      clock_out_select <= 2'h0;
      periodic_irq_select_reg <= PER_NONE;
      alarm_minute_reg <= 8'h0;
      alarm_hour_reg <= 8'h0;
      alarm_weekday_reg <= 8'h0;
      alarm_irq_enable <= 1'b0;
      irq_mask <= 2'h0;
    end else if (wr_low) begin
      case (aw_addr)
        OFF_CLOCK_CONTROL: begin
          count_start_request <= w_data[CTL_START_BIT];
          if (!count_running_flag) begin
            hour_format_select <= w_data[CTL_H24_BIT];
            clock_out_enable <= w_data[CTL_COE_BIT];
          end
        end
        OFF_CLOCK_SOURCE: begin
          if (!count_running_flag) begin
            clock_out_select <= w_data[1:0];
          end
        end
        OFF_PERIODIC_SELECT: begin
          if (!count_running_flag) begin
            periodic_irq_select_reg <= rtcc_per_e'(w_data[2:0]);
          end
        end
        OFF_ALARM_MINUTE: alarm_minute_reg <= w_data[7:0];
        OFF_ALARM_HOUR: alarm_hour_reg <= {w_data[7], 1'b0, w_data[5:0]};
        OFF_ALARM_WEEKDAY: alarm_weekday_reg <= {w_data[7], 4'h0, w_data[2:0]};
        OFF_IRQ_FLAG: alarm_irq_enable <= w_data[IF_AIE_BIT];
        OFF_IRQ_MASK: irq_mask <= w_data[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  always_comb begin
    wr_hit = (aw_addr <= OFF_IRQ_MASK) && (aw_addr[1:0] == 2'h0);
    rd_hit = (s_axi_araddr <= OFF_IRQ_MASK) && (s_axi_araddr[1:0] == 2'h0);
    rd_word = 32'h0;
    case (s_axi_araddr)
      // [R8] busy visible beside seconds
      OFF_SECONDS: rd_word = {24'h0, update_busy_flag, cur_time.sec};
      OFF_MINUTES: rd_word = {25'h0, cur_time.min};
      OFF_HOURS: rd_word = {26'h0, cur_time.hour};
      OFF_WEEKDAY: rd_word = {29'h0, cur_time.wday};
      OFF_DAY: rd_word = {26'h0, cur_time.day};
      OFF_MONTH: rd_word = {27'h0, cur_time.mon};
      OFF_YEAR: rd_word = {24'h0, cur_time.year};
      OFF_CLOCK_CONTROL: rd_word = {27'h0, clock_out_enable, cur_time.pm,
                                    hour_format_select, count_running_flag,
                                    count_start_request};
      OFF_CLOCK_SOURCE: rd_word = {30'h0, clock_out_select};
      OFF_PERIODIC_SELECT: rd_word = {29'h0, periodic_irq_select_reg};
      OFF_ALARM_MINUTE: rd_word = {24'h0, alarm_minute_reg};
      OFF_ALARM_HOUR: rd_word = {24'h0, alarm_hour_reg};
      OFF_ALARM_WEEKDAY: rd_word = {24'h0, alarm_weekday_reg};
      OFF_IRQ_FLAG: rd_word = {29'h0, alarm_irq_enable, alarm_flag, periodic_flag};
      OFF_IRQ_STATUS: rd_word = {30'h0, periodic_irq_control_reg};
      OFF_IRQ_MASK: rd_word = {30'h0, irq_mask};
      default: rd_word = 32'h0;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// *** test/rtcc_props.sv ***
// port-level checks of the calendar clock core
`timescale 1ns/1ps
module rtcc_props
  import rtcc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // outputs
  input wire logic irq_o,
  input wire logic clock_out_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write taken before response");
  // upper bits of every register word read as zero
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_error_data: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
    |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  a_quiet_reset: assert property ($fell(rst_i) |-> !irq_o && !clock_out_o && !s_axi_bvalid)
    else $error("outputs active after reset");
endmodule

bind rtcc_top rtcc_props u_props (.*);

// *** test/tb.sv ***
// self-checking bench for the calendar clock core over axi4-lite
`timescale 1ns/1ps
module tb
  import rtcc_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic count_src_tick_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o, clock_out_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, d;
  logic [1:0] r;
  logic [2:0] div = 3'h0;
  int failures = 0;
  int n_checks = 0;
  int ticks = 0;
  int t0, n;
  logic [7:0] ra [6] = '{OFF_SECONDS, OFF_HOURS, OFF_DAY, OFF_MONTH, OFF_CLOCK_CONTROL, 8'h38};
  logic [31:0] re [6] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h4, 32'h0};

  // a short second keeps the run small: 16 ticks of 8 cycles each
  rtcc_top #(.SUBCLK_PER_SEC(16)) dut (.*);

  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  always_ff @(posedge ref_clk_i) begin
    div <= div + 3'h1;
    count_src_tick_i <= (div == 3'h7);
    ticks <= ticks + int'(count_src_tick_i);
  end

  task automatic finish_test();
    if (failures == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      failures++;
      finish_test();
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask

  initial begin
    repeat (6) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) rc(ra[i], re[i]);
    rd(8'h40);
    chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    // seconds, minutes and hours one step from rolling over
    wr(OFF_SECONDS, 32'h59);
    wr(OFF_MINUTES, 32'h59);
    wr(OFF_HOURS, 32'h23);
    rc(OFF_HOURS, 32'h23);
    rc(OFF_SECONDS, 32'h59);
    wr(OFF_ALARM_MINUTE, 32'h80);
    wr(OFF_IRQ_FLAG, 32'h4);
    wr(OFF_IRQ_MASK, 32'h3);
    wr(OFF_PERIODIC_SELECT, {29'h0, PER_SEC});
    t0 = ticks;
    wr(OFF_CLOCK_CONTROL, 32'h5);
    // only the running flag is polled until it shows
    for (int k = 0; k < 20; k++) begin
      rd(OFF_CLOCK_CONTROL);
      if (d[CTL_RUN_BIT]) break;
    end
    // one extra tick allowed for the poll's own read latency
    chk({d[CTL_RUN_BIT], (ticks - t0) <= START_TICKS + 1}, 2'h3);
    for (int k = 0; k < 600 && irq_o !== 1'b1; k++) @(posedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h1);
    repeat (4) @(posedge ref_clk_i);
    rc(OFF_IRQ_FLAG, 32'h7);
    rc(OFF_IRQ_STATUS, 32'h3);
    rc(OFF_MINUTES, 32'h0);
    rc(OFF_HOURS, 32'h0);
    rc(OFF_DAY, 32'h2);
    wr(OFF_MINUTES, 32'h12);
    rc(OFF_MINUTES, 32'h0);
    wr(OFF_IRQ_MASK, 32'h0);
    repeat (3) @(posedge ref_clk_i);
    chk({31'h0, irq_o}, 32'h0);
    wr(OFF_IRQ_FLAG, 32'h7);
    wr(OFF_IRQ_STATUS, 32'h3);
    rc(OFF_IRQ_STATUS, 32'h0);
    // keep reading until an update is caught in flight
    for (int k = 0; k < 200; k++) begin
      rd(OFF_SECONDS);
      if (d[SEC_BUSY_BIT]) break;
    end
    chk({31'h0, d[SEC_BUSY_BIT]}, 32'h1);
    t0 = ticks;
    wr(OFF_CLOCK_CONTROL, 32'h4);
    for (int k = 0; k < 20; k++) begin
      rd(OFF_CLOCK_CONTROL);
      if (!d[CTL_RUN_BIT]) break;
    end
    chk({d[CTL_RUN_BIT], (ticks - t0) <= STOP_TICKS + 1}, 2'h1);
    chk({31'h0, clock_out_o}, 32'h0);
    wr(OFF_CLOCK_CONTROL, 32'h14);
    repeat (2) @(posedge ref_clk_i);
    d = {31'h0, clock_out_o};
    // divided source toggles once per tick, one tick every 8 cycles
    repeat (8) @(posedge ref_clk_i);
    chk({31'h0, clock_out_o}, {31'h0, ~d[0]});
    finish_test();
  end
endmodule
